// >>> kaw_pkg.sv
package kaw_pkg;
   // Timeout value is in milliseconds, as the feature field carries it
   localparam int TMO_W = 32;
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
   localparam int TICK_CNT_W = 17;
   localparam logic [TMO_W-1:0] TMO_MIN_DEF = 32'h0000_0001;
   localparam logic [TMO_W-1:0] TMO_MAX_DEF = 32'hFFFF_FFFF;
   localparam logic [TMO_W-1:0] TMO_RESET = 32'h0000_0000;
   localparam logic [1:0] SHN_NONE = 2'h0;
   localparam logic [1:0] SHST_NORMAL = 2'h0;
   // Completion status codes for the configure command
   localparam logic [7:0] STS_SUCCESS = 8'h00;
   localparam logic [7:0] STS_TMO_INVALID = 8'h0E;
   // Error log code for an expired timer
   localparam logic [7:0] ERR_TMO_EXPIRED = 8'h0C;
endpackage : kaw_pkg

// >>> kaw_tick_gen.sv
`timescale 1ns/1ps
// ****************************************
// Millisecond tick source
// ****************************************
module kaw_tick_gen #(
   parameter int CYCLES = kaw_pkg::TICK_CYCLES,
   parameter int CNT_W = kaw_pkg::TICK_CNT_W
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_restart,
   output logic o_tick
);
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic tick_reg;
   logic tick_next;

   always_comb begin
      cnt_next = cnt_reg + 1'b1;
      tick_next = 1'b0;
      // Restart aligns the tick with a timer reload
      if (i_restart) begin
         cnt_next = '0;
      end else if (cnt_reg == CNT_W'(CYCLES - 1)) begin
         cnt_next = '0;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign o_tick = tick_reg;
endmodule : kaw_tick_gen

// >>> kaw_watchdog.sv
`timescale 1ns/1ps
// Contract
// (RULE1) Select zero: only keep-alive restarts timer
// (RULE2) Command mode: expiry without keep-alive times out
// (RULE3) Host times out missing keep-alive completion
// (RULE4) Host sends keep-alive every half interval
// (RULE5) Traffic-restart support advertised to host
// (RULE6) No support: command mode, select reads zero
// (RULE7) Traffic mode: activity restarts timer at expiry
// (RULE8) Traffic mode: idle interval declares timeout
// (RULE9) Host times out without any completion
// (RULE10) Host restarts timer after completions
// (RULE11) Host polls completions every half interval
// (RULE12) Idle host sends keep-alive at half interval
// (RULE13) Keep-alive optional over local transport
// (RULE14) Local transport imposes no timeout limits
// (RULE15) Active only enabled, ready, no shutdown, nonzero
// (RULE16) Timeout logs error and sets fatal flag
// (RULE17) Activation loads configured timeout value
// (RULE18) Invalid timeout rejected, low value raised
// (RULE19) Activity flag set by commands, cleared on reload
// (RULE20) Count down in fixed ticks, reload on restart
module kaw_watchdog #(
   parameter bit SUPPORT_KA = 1'b1,
   parameter bit SUPPORT_TRAFFIC = 1'b1,
   parameter logic [31:0] TMO_MIN = kaw_pkg::TMO_MIN_DEF,
   parameter logic [31:0] TMO_MAX = kaw_pkg::TMO_MAX_DEF,
   parameter int TICK_CYCLES = kaw_pkg::TICK_CYCLES
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   input wire logic i_controller_enable_bit,
   input wire logic i_controller_ready_flag,
   input wire logic [1:0] i_shutdown_request_field,
   input wire logic [1:0] i_shutdown_state_field,
   input wire logic i_traffic_restart_select,
   input wire logic i_tmo_wr,
   input wire logic [31:0] i_tmo_wdata,
   input wire logic i_keepalive_cmd,
   input wire logic i_any_cmd,
   output logic o_traffic_support,
   output logic o_traffic_restart_select,
   output logic [31:0] o_keepalive_timeout_value,
   output logic o_tmo_done,
   output logic [7:0] o_tmo_status,
   output logic o_active,
   output logic [31:0] o_remaining,
   output logic o_err_log,
   output logic [7:0] o_err_code,
   output logic o_fatal_status_flag
);
   // ****************************************
   // State
   // ****************************************
   logic [31:0] tmo_reg, tmo_next;
   logic sel_reg, sel_next;
   logic done_reg, done_next;
   logic [7:0] sts_reg, sts_next;
   logic act_reg, act_next;
   logic [31:0] cnt_reg, cnt_next;
   logic seen_reg, seen_next;
   logic err_reg, err_next;
   logic fatal_reg, fatal_next;
   logic active;
   logic tick;
   logic expire;
   logic reload;
   logic timeout;

   function automatic logic [31:0] clamp_min(input logic [31:0] v);
      clamp_min = (v < TMO_MIN) ? TMO_MIN : v;
   endfunction : clamp_min

   // ****************************************
   // Timeout configuration
   // ****************************************
   always_comb begin
      tmo_next = tmo_reg;
      sel_next = sel_reg;
      done_next = i_tmo_wr;
      sts_next = sts_reg;
      if (i_tmo_wr) begin
         // Zero or too large leaves the old value standing
         if (!SUPPORT_KA || i_tmo_wdata == 32'h0000_0000 ||
             i_tmo_wdata > TMO_MAX) begin // [RULE18] [RULE13] [RULE14]
            sts_next = kaw_pkg::STS_TMO_INVALID;
         end else begin
            tmo_next = clamp_min(i_tmo_wdata); // [RULE18]
            sts_next = kaw_pkg::STS_SUCCESS;
         end
      end
      // Select is forced low when traffic restart is unsupported
      sel_next = SUPPORT_TRAFFIC & i_traffic_restart_select; // [RULE6]
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         tmo_reg <= kaw_pkg::TMO_RESET;
         sel_reg <= 1'b0;
         done_reg <= 1'b0;
         sts_reg <= kaw_pkg::STS_SUCCESS;
      end else begin
         tmo_reg <= tmo_next;
         sel_reg <= sel_next;
         done_reg <= done_next;
         sts_reg <= sts_next;
      end
   end

   // ****************************************
   // Timer
   // ****************************************
   assign active = i_controller_enable_bit && i_controller_ready_flag &&
      i_shutdown_request_field == kaw_pkg::SHN_NONE &&
      i_shutdown_state_field == kaw_pkg::SHST_NORMAL &&
      tmo_reg != 32'h0000_0000; // [RULE15]
   assign expire = act_reg && tick && cnt_reg == 32'h0000_0001;
   // Activity seen in the final cycle still counts toward the interval
   assign timeout = expire && !(sel_reg ?
      (seen_reg || i_any_cmd) : i_keepalive_cmd); // [RULE2] [RULE8]
   assign reload = (active && !act_reg) || (act_reg && !sel_reg &&
      i_keepalive_cmd) || (expire && !timeout); // [RULE1] [RULE7] [RULE17]

   kaw_tick_gen #(
      .CYCLES(TICK_CYCLES),
      .CNT_W(kaw_pkg::TICK_CNT_W)
   ) u_tick (
      .i_clk(I_CLK_SYS),
      .i_rst(I_RST),
      .i_restart(reload),
      .o_tick(tick)
   );

   always_comb begin
      act_next = active;
      cnt_next = cnt_reg;
      seen_next = seen_reg;
      err_next = 1'b0;
      fatal_next = fatal_reg;
      if (!active) begin
         cnt_next = 32'h0000_0000;
         seen_next = 1'b0;
      end else if (reload) begin
         cnt_next = tmo_reg; // [RULE17] [RULE20]
         seen_next = 1'b0; // [RULE19]
      end else if (timeout) begin
         cnt_next = 32'h0000_0000;
         err_next = 1'b1; // [RULE16]
         fatal_next = 1'b1; // [RULE16]
         act_next = 1'b1;
      end else begin
         if (tick && cnt_reg != 32'h0000_0000) begin
            cnt_next = cnt_reg - 32'h0000_0001; // [RULE20]
         end
         if (i_any_cmd) begin
            seen_next = 1'b1; // [RULE19]
         end
      end
      // Fatal is cleared only by a controller disable or by I_RST
      if (!i_controller_enable_bit) begin
         fatal_next = 1'b0;
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         act_reg <= 1'b0;
         cnt_reg <= 32'h0000_0000;
         seen_reg <= 1'b0;
         err_reg <= 1'b0;
         fatal_reg <= 1'b0;
      end else begin
         act_reg <= act_next;
         cnt_reg <= cnt_next;
         seen_reg <= seen_next;
         err_reg <= err_next;
         fatal_reg <= fatal_next;
      end
   end

   assign o_traffic_support = SUPPORT_TRAFFIC; // [RULE5]
   assign o_traffic_restart_select = sel_reg;
   assign o_keepalive_timeout_value = tmo_reg;
   assign o_tmo_done = done_reg;
   assign o_tmo_status = sts_reg;
   assign o_active = act_reg;
   assign o_remaining = cnt_reg;
   assign o_err_log = err_reg;
   assign o_err_code = kaw_pkg::ERR_TMO_EXPIRED;
   assign o_fatal_status_flag = fatal_reg;

   // ****************************************
   // Checks
   // ****************************************
   a_inactive_quiet: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      !active |=> !err_reg) // [RULE15]
      else $error("timeout while inactive");
   a_timeout_fatal: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      err_reg |-> fatal_reg) // [RULE16]
      else $error("fatal flag not set on timeout");
   a_activate_load: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      active && !act_reg |=> cnt_reg == $past(tmo_reg)) // [RULE17]
      else $error("activation did not load timeout");
   a_zero_reject: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      i_tmo_wr && i_tmo_wdata == 32'h0000_0000 |=>
      o_tmo_status == kaw_pkg::STS_TMO_INVALID && $stable(tmo_reg))
      // [RULE18]
      else $error("zero timeout accepted");
   a_select_support: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      !SUPPORT_TRAFFIC |-> !sel_reg) // [RULE6]
      else $error("select set without support");
   a_cmd_restart: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      act_reg && active && !sel_reg && i_keepalive_cmd |=>
      cnt_reg == $past(tmo_reg) && !err_reg) // [RULE1]
      else $error("keep-alive did not restart timer");
   a_traffic_restart: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RST)
      active && expire && sel_reg && seen_reg |=> !err_reg) // [RULE7]
      else $error("traffic mode timed out with activity");
   a_cmd_expire: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      active && expire && !sel_reg && !i_keepalive_cmd |=> err_reg)
      // [RULE2]
      else $error("command mode missed timeout");
   a_idle_expire: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      active && expire && sel_reg && !seen_reg && !i_any_cmd |=> err_reg)
      // [RULE8]
      else $error("traffic mode missed timeout");
   a_countdown: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      active && act_reg && tick && !reload && !timeout &&
      cnt_reg != 32'h0000_0000 |=> cnt_reg == $past(cnt_reg) - 1) // [RULE20]
      else $error("timer did not count down");
   c_timeout: cover property (@(posedge I_CLK_SYS) err_reg);
   c_traffic_restart: cover property (@(posedge I_CLK_SYS)
      expire && sel_reg && seen_reg);
   c_ka_restart: cover property (@(posedge I_CLK_SYS)
      act_reg && i_keepalive_cmd && !sel_reg);
   c_reject: cover property (@(posedge I_CLK_SYS)
      done_reg && sts_reg == kaw_pkg::STS_TMO_INVALID);
endmodule : kaw_watchdog

// >>> kaw_host_model.sv
`timescale 1ns/1ps
// ****************************************
// Host command traffic model
// ****************************************
module kaw_host_model #(
   parameter int HALF = 6
) (
   input wire logic i_clk,
   input wire logic i_run,
   input wire logic i_traffic,
   output logic o_keepalive_cmd,
   output logic o_any_cmd
);
   int cnt = 0;
   initial begin
      o_keepalive_cmd = 1'b0;
      o_any_cmd = 1'b0;
   end
   // Half-interval cadence leaves margin for latency and tick grain
   always @(posedge i_clk) begin
      cnt <= (i_run && cnt < HALF - 1) ? cnt + 1 : 0;
      o_any_cmd <= #1 i_run && cnt == HALF - 1;
      // Traffic mode sends plain commands only, no keep-alive
      o_keepalive_cmd <= #1 i_run && !i_traffic && cnt == HALF - 1;
   end
endmodule : kaw_host_model

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, rst = 1'b1, en = 1'b0, rdy = 1'b0, sel = 1'b0;
   logic [1:0] shn = 2'h0, shst = 2'h0;
   logic kwr = 1'b0, run = 1'b0, trf = 1'b0, ka, anyc;
   logic [31:0] kdata = 32'h0, val, rem;
   logic sup, selo, done, act, elog, fat;
   logic [7:0] sts, ecode;
   int failures = 0, total_checks = 0, err_seen = 0;
   kaw_watchdog #(.TMO_MIN(32'h0000_0002), .TMO_MAX(32'h0000_0010),
      .TICK_CYCLES(4)) DUT (.I_CLK_SYS(clk), .I_RST(rst),
      .i_controller_enable_bit(en), .i_controller_ready_flag(rdy),
      .i_shutdown_request_field(shn), .i_shutdown_state_field(shst),
      .i_traffic_restart_select(sel), .i_tmo_wr(kwr), .i_tmo_wdata(kdata),
      .i_keepalive_cmd(ka), .i_any_cmd(anyc), .o_traffic_support(sup),
      .o_traffic_restart_select(selo), .o_keepalive_timeout_value(val),
      .o_tmo_done(done), .o_tmo_status(sts), .o_active(act),
      .o_remaining(rem), .o_err_log(elog), .o_err_code(ecode),
      .o_fatal_status_flag(fat));
   kaw_host_model #(.HALF(6)) host (.i_clk(clk), .i_run(run),
      .i_traffic(trf), .o_keepalive_cmd(ka), .o_any_cmd(anyc));
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (elog === 1'b1) err_seen++;
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input string name, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic give_verdict;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   task automatic cfg(input logic [31:0] d, ev, input logic [7:0] es);
      kwr = 1'b1;
      kdata = d;
      tick(1);
      kwr = 1'b0;
      check("done", 32'h1, {31'h0, done});
      check("status", {24'h0, es}, {24'h0, sts});
      check("value", ev, val);
      // Idle edge so the next call does not re-raise the strobe at once
      tick(1);
   endtask : cfg
   task automatic wait_err(input int bound);
      int i;
      for (i = 0; i < bound && elog !== 1'b1; i++) tick(1);
      if (i == bound) begin
         failures++;
         $display("[ERR] err_log expected 1 seen %b", elog);
         give_verdict();
      end
      check("err_code", 32'h0C, {24'h0, ecode});
      check("fatal", 32'h1, {31'h0, fat});
      tick(1);
      check("remaining", 32'h0, rem);
   endtask : wait_err
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      check("support", 32'h1, {31'h0, sup});
      check("sel_out", 32'h0, {31'h0, selo});
      check("active", 32'h0, {31'h0, act});
      check("value", 32'h0, val);
   endtask : t_reset
   task automatic t_config;
      cfg(32'h0, 32'h0, 8'h0E);
      cfg(32'h11, 32'h0, 8'h0E);
      cfg(32'h1, 32'h2, 8'h00);
      cfg(32'h10, 32'h10, 8'h00);
      cfg(32'h3, 32'h3, 8'h00);
   endtask : t_config
   task automatic t_activate;
      en = 1'b1;
      rdy = 1'b1;
      tick(1);
      check("active", 32'h1, {31'h0, act});
      check("remaining", 32'h3, rem);
      shn = 2'h1;
      tick(1);
      check("active", 32'h0, {31'h0, act});
      shn = 2'h0;
      tick(1);
      check("remaining", 32'h3, rem);
   endtask : t_activate
   task automatic t_cmd_mode;
      run = 1'b1;
      tick(40);
      check("err_seen", 32'h0, err_seen);
      trf = 1'b1;
      wait_err(20);
   endtask : t_cmd_mode
   task automatic t_traffic;
      run = 1'b0;
      en = 1'b0;
      tick(2);
      check("fatal", 32'h0, {31'h0, fat});
      sel = 1'b1;
      en = 1'b1;
      run = 1'b1;
      tick(40);
      check("sel_out", 32'h1, {31'h0, selo});
      check("err_seen", 32'h1, err_seen);
      run = 1'b0;
      wait_err(40);
   endtask : t_traffic
   initial begin
      tick(20);
      rst = 1'b0;
      tick(1);
      t_reset();
      t_config();
      t_activate();
      t_cmd_mode();
      t_traffic();
      give_verdict();
   end
endmodule : testbench
